// File: rtl/bldgc_pkg.sv
// constants, register layouts and carrier types for the backlight controller
package bldgc_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_BL_CTRL = 8'h03;
    localparam logic [7:0] ADDR_MAIN_CUR = 8'h04;
    localparam logic [7:0] ADDR_SUB_CUR = 8'h05;
    localparam logic [7:0] ADDR_PIN_DIR = 8'h06;
    localparam logic [7:0] ADDR_PIN_DATA = 8'h07;
    localparam logic [7:0] ADDR_EXT_GATE = 8'h2B;

    // ------------------------------------------------------------
    // reset values and fixed codes
    // ------------------------------------------------------------
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;
    localparam logic [7:0] CODE_MAX = 8'hFF;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint FADE_SLOW_NS = 1300000000;
    localparam longint FADE_FAST_NS = 650000000;
    localparam longint CLK_PERIOD_NS = 5;
    localparam longint FADE_STEPS = 255;
    // full scale is 255 steps, so one step interval is a 255th of the ramp
    localparam longint STEP_SLOW_CYC = FADE_SLOW_NS / (FADE_STEPS * CLK_PERIOD_NS);
    localparam longint STEP_FAST_CYC = FADE_FAST_NS / (FADE_STEPS * CLK_PERIOD_NS);
    localparam int CNT_W = 20;

    typedef logic [CNT_W-1:0] bldgc_cnt_t;

    // ------------------------------------------------------------
    // register layouts
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] rsvd;
        logic fade_fast;
        logic fade_sub_sel;
        logic fade_en;
        logic shared_display_mode;
        logic main_en;
        logic sub_en;
    } bldgc_ctrl_t;

    typedef struct packed {
        logic [2:0] rsvd_hi;
        logic pwm_pin_en;
        logic rsvd_lo;
        logic [2:0] pin_direction_bits;
    } bldgc_pin_dir_t;

    typedef struct packed {
        logic [5:0] rsvd;
        logic main_gate;
        logic sub_gate;
    } bldgc_ext_gate_t;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bldgc_reg_req_t;

    typedef struct packed {
        logic on;
        logic [7:0] code;
    } bldgc_sink_t;

endpackage

// File: rtl/bldgc_top.sv
// backlight sink control, fade ramps, external gating and three-pin port
//
// Behaviour
// [R1] separate 8-bit current codes for main and sub sinks, 0.1 mA per step
// [R2] main code at 0x04, sub code at 0x05; zero off, all-ones full
// [R3] shared display bit set drives both sinks from the main code
// [R4] control bit 1 enables main sink, bit 0 enables sub sink
// [R5] gating bits in 0x2B make a sink follow external PWM input
// [R6] PWM input active high; gated sink conducts only while it is high
// [R7] PWM-pin enable makes pin 0 the PWM input, overriding its direction
// [R8] only pin 0 may serve as PWM input; pins 1, 2 plain
// [R9] fade enable ramps a newly written code instead of applying it
// [R10] fade rate bit: 0 gives 1.3 s, 1 gives 0.65 s full scale
// [R11] smaller code changes fade in proportionally shorter time
// [R12] fade select bit: 0 fades main sink, 1 fades sub sink
// [R13] shared display with fade select 0 fades both sinks together
// [R14] software loads code, rate, select, enable, then target, in order
// [R15] bits 2:0 of 0x06 set pin directions, 1 output, 0 input
// [R16] output pin drives its bit from data register 0x07
// [R17] data register reads sampled pin levels whatever the direction
// [R18] a register write takes effect on the final acknowledge edge
// [R19] write is device address, register select byte, then one data byte
// [R20] fade steps active code by one per interval, 255 steps full scale
`timescale 1ns/1ps
module bldgc_top #(
    parameter bldgc_pkg::bldgc_cnt_t STEP_SLOW =
        bldgc_pkg::bldgc_cnt_t'(bldgc_pkg::STEP_SLOW_CYC),
    parameter bldgc_pkg::bldgc_cnt_t STEP_FAST =
        bldgc_pkg::bldgc_cnt_t'(bldgc_pkg::STEP_FAST_CYC)
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire bldgc_pkg::bldgc_reg_req_t reg_req_i,
    output bldgc_pkg::bldgc_sink_t main_sink_o,
    output bldgc_pkg::bldgc_sink_t sub_sink_o,
    output logic [7:0] reg_rdata_o,
    input wire logic [2:0] gpio_in_i,
    output logic [2:0] gpio_out_o,
    output logic [2:0] gpio_oe_o
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] step_toward(input logic [7:0] act,
                                               input logic [7:0] tgt);
        logic [7:0] res;
        res = act;
        if (act < tgt) begin
            res = act + 8'h01;
        end else if (act > tgt) begin
            res = act - 8'h01;
        end
        return res;
    endfunction

    function automatic logic wr_hit(input bldgc_pkg::bldgc_reg_req_t req,
                                    input logic [7:0] addr);
        return req.wr && (req.addr == addr);
    endfunction

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    bldgc_pkg::bldgc_ctrl_t ctrl;
    logic [7:0] main_code;
    logic [7:0] sub_code;
    bldgc_pkg::bldgc_pin_dir_t pin_dir;
    logic [2:0] pin_data_out;
    bldgc_pkg::bldgc_ext_gate_t ext_gate;

    // the serial port raises wr on the final acknowledge edge
    // [R18] write commits on strobe
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ctrl <= bldgc_pkg::bldgc_ctrl_t'(bldgc_pkg::RST_REG);
            pin_dir <= bldgc_pkg::bldgc_pin_dir_t'(bldgc_pkg::RST_REG);
            ext_gate <= bldgc_pkg::bldgc_ext_gate_t'(bldgc_pkg::RST_REG);
        end else if (ce_i) begin
            if (wr_hit(reg_req_i, bldgc_pkg::ADDR_BL_CTRL)) begin
                ctrl <= bldgc_pkg::bldgc_ctrl_t'({2'h0,
                                                  reg_req_i.wdata[5:0]});
            end
            if (wr_hit(reg_req_i, bldgc_pkg::ADDR_PIN_DIR)) begin
                pin_dir <= bldgc_pkg::bldgc_pin_dir_t'({3'h0,
                    reg_req_i.wdata[4], 1'h0, reg_req_i.wdata[2:0]});
            end
            if (wr_hit(reg_req_i, bldgc_pkg::ADDR_EXT_GATE)) begin
                ext_gate <= bldgc_pkg::bldgc_ext_gate_t'({6'h00,
                                                          reg_req_i.wdata[1:0]});
            end
        end
    end

    // [R1] two current codes
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            main_code <= bldgc_pkg::RST_REG;
            sub_code <= bldgc_pkg::RST_REG;
        end else if (ce_i) begin
            // [R2] code register decode
            if (wr_hit(reg_req_i, bldgc_pkg::ADDR_MAIN_CUR)) begin
                main_code <= reg_req_i.wdata;
            end
            if (wr_hit(reg_req_i, bldgc_pkg::ADDR_SUB_CUR)) begin
                sub_code <= reg_req_i.wdata;
            end
        end
    end

    // [R16] output data latch
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            pin_data_out <= bldgc_pkg::RST_REG[2:0];
        end else if (ce_i) begin
            if (wr_hit(reg_req_i, bldgc_pkg::ADDR_PIN_DATA)) begin
                pin_data_out <= reg_req_i.wdata[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // pin input synchronisers
    // ------------------------------------------------------------
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_s3;
    logic [2:0] pin_lvl;

    // a level counts only once stages two and three agree
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            pin_s1 <= 3'h0;
            pin_s2 <= 3'h0;
            pin_s3 <= 3'h0;
            pin_lvl <= 3'h0;
        end else if (ce_i) begin
            pin_s1 <= gpio_in_i;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            // [R17] sampled pin levels
            for (int i = 0; i < 3; i++) begin
                if (pin_s2[i] == pin_s3[i]) begin
                    pin_lvl[i] <= pin_s3[i];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // external PWM source
    // ------------------------------------------------------------
    logic pwm_lvl;

    // [R8] only pin 0 feeds the PWM path
    // with the pin not taken over, gated sinks see a low input
    assign pwm_lvl = pin_dir.pwm_pin_en & pin_lvl[0];

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            gpio_out_o <= 3'h0;
            gpio_oe_o <= 3'h0;
        end else if (ce_i) begin
            // [R15] per-pin direction
            gpio_oe_o[2:1] <= pin_dir.pin_direction_bits[2:1];
            // [R7] PWM use forces pin 0 to input
            gpio_oe_o[0] <= pin_dir.pin_direction_bits[0] &
                            ~pin_dir.pwm_pin_en;
            // [R16] drive data bits
            gpio_out_o <= pin_data_out;
        end
    end

    // ------------------------------------------------------------
    // fade engine
    // ------------------------------------------------------------
    logic [7:0] main_act;
    logic [7:0] sub_act;
    logic main_fading;
    logic sub_fading;
    logic ramp_busy;
    logic step_tick;
    bldgc_pkg::bldgc_cnt_t step_cnt;
    bldgc_pkg::bldgc_cnt_t step_limit;

    // [R12] fade target selection
    // [R13] shared mode fades main, which drives both sinks
    assign main_fading = ctrl.fade_en & ~ctrl.fade_sub_sel;
    assign sub_fading = ctrl.fade_en & ctrl.fade_sub_sel;
    assign ramp_busy = (main_fading && (main_act != main_code)) ||
                       (sub_fading && (sub_act != sub_code));

    // [R10] rate select
    assign step_limit = ctrl.fade_fast ? STEP_FAST : STEP_SLOW;
    // >= so a rate change mid-interval cannot strand the counter
    assign step_tick = ramp_busy &&
                       (step_cnt >= step_limit - bldgc_pkg::bldgc_cnt_t'(1));

    // [R20] step interval counter
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            step_cnt <= '0;
        end else if (ce_i) begin
            if (!ramp_busy || step_tick) begin
                step_cnt <= '0;
            end else begin
                step_cnt <= step_cnt + bldgc_pkg::bldgc_cnt_t'(1);
            end
        end
    end

    // [R9] ramp or apply at once
    // [R11] one count per tick keeps time proportional to the change
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            main_act <= bldgc_pkg::RST_REG;
            sub_act <= bldgc_pkg::RST_REG;
        end else if (ce_i) begin
            if (!main_fading) begin
                main_act <= main_code;
            end else if (step_tick) begin
                main_act <= step_toward(main_act, main_code);
            end
            if (!sub_fading) begin
                sub_act <= sub_code;
            end else if (step_tick) begin
                sub_act <= step_toward(sub_act, sub_code);
            end
        end
    end

    // ------------------------------------------------------------
    // sink drive
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            main_sink_o <= '0;
            sub_sink_o <= '0;
        end else if (ce_i) begin
            // [R4] per-sink enables
            // [R5] gated sinks follow the PWM input
            // [R6] active high gating
            main_sink_o.on <= ctrl.main_en & (~ext_gate.main_gate | pwm_lvl);
            sub_sink_o.on <= ctrl.sub_en & (~ext_gate.sub_gate | pwm_lvl);
            main_sink_o.code <= main_act;
            // [R3] shared display uses main code
            sub_sink_o.code <= ctrl.shared_display_mode ? main_act : sub_act;
        end
    end

    // ------------------------------------------------------------
    // read back
    // ------------------------------------------------------------
    logic [7:0] next_rdata;

    always_comb begin
        if (reg_req_i.addr == bldgc_pkg::ADDR_BL_CTRL) begin
            next_rdata = ctrl;
        end else if (reg_req_i.addr == bldgc_pkg::ADDR_MAIN_CUR) begin
            next_rdata = main_code;
        end else if (reg_req_i.addr == bldgc_pkg::ADDR_SUB_CUR) begin
            next_rdata = sub_code;
        end else if (reg_req_i.addr == bldgc_pkg::ADDR_PIN_DIR) begin
            next_rdata = pin_dir;
        end else if (reg_req_i.addr == bldgc_pkg::ADDR_PIN_DATA) begin
            // [R17] pin levels, not the latch
            next_rdata = {5'h00, pin_lvl};
        end else if (reg_req_i.addr == bldgc_pkg::ADDR_EXT_GATE) begin
            next_rdata = ext_gate;
        end else begin
            next_rdata = bldgc_pkg::UNMAPPED_DATA;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            reg_rdata_o <= bldgc_pkg::RST_REG;
        end else if (ce_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_main_code_write: assert property ( // [R1]
        @(posedge clk_sys_i) disable iff (srst_i)
        ce_i && wr_hit(reg_req_i, bldgc_pkg::ADDR_MAIN_CUR)
        |=> main_code == $past(reg_req_i.wdata))
        else $error("main code not stored");

    a_sub_code_write: assert property ( // [R2]
        @(posedge clk_sys_i) disable iff (srst_i)
        ce_i && wr_hit(reg_req_i, bldgc_pkg::ADDR_SUB_CUR)
        |=> sub_code == $past(reg_req_i.wdata))
        else $error("sub code not stored");

    a_shared_drive_code: assert property ( // [R3]
        @(posedge clk_sys_i) disable iff (srst_i)
        ce_i && ctrl.shared_display_mode |=> sub_sink_o.code == $past(main_act))
        else $error("sub sink not on main code");

    a_sink_enable_off: assert property ( // [R4]
        @(posedge clk_sys_i) disable iff (srst_i)
        ce_i && !ctrl.main_en |=> !main_sink_o.on)
        else $error("main sink on while disabled");

    a_gate_low_off: assert property ( // [R6]
        @(posedge clk_sys_i) disable iff (srst_i)
        ce_i && ext_gate.sub_gate && !pwm_lvl |=> !sub_sink_o.on)
        else $error("gated sink on with pwm low");

    a_gate_high_on: assert property ( // [R5]
        @(posedge clk_sys_i) disable iff (srst_i)
        ce_i && ctrl.main_en && ext_gate.main_gate && pwm_lvl
        |=> main_sink_o.on)
        else $error("gated sink off with pwm high");

    a_pin0_pwm_override: assert property ( // [R7]
        @(posedge clk_sys_i) disable iff (srst_i)
        ce_i && pin_dir.pwm_pin_en |=> !gpio_oe_o[0])
        else $error("pin 0 driven while pwm input");

    a_pin_out_drive: assert property ( // [R16]
        @(posedge clk_sys_i) disable iff (srst_i)
        ce_i && pin_dir.pin_direction_bits[1]
        |=> gpio_oe_o[1] && gpio_out_o[1] == $past(pin_data_out[1]))
        else $error("pin 1 not driving data bit");

    a_pin_data_read: assert property ( // [R17]
        @(posedge clk_sys_i) disable iff (srst_i)
        ce_i && reg_req_i.addr == bldgc_pkg::ADDR_PIN_DATA
        |=> reg_rdata_o == {5'h00, $past(pin_lvl)})
        else $error("pin data read not pin level");

    a_nofade_direct: assert property ( // [R9]
        @(posedge clk_sys_i) disable iff (srst_i)
        ce_i && !main_fading |=> main_act == $past(main_code))
        else $error("unfaded code not applied at once");

    a_fade_hold_step: assert property ( // [R20]
        @(posedge clk_sys_i) disable iff (srst_i)
        ce_i && main_fading && !step_tick |=> $stable(main_act))
        else $error("fade moved without a tick");

    a_fade_one_count: assert property ( // [R11]
        @(posedge clk_sys_i) disable iff (srst_i)
        ce_i && main_fading && step_tick && main_act < main_code
        |=> main_act == $past(main_act) + 8'h01)
        else $error("fade step not one count");

    a_rate_interval: assert property ( // [R10]
        @(posedge clk_sys_i) disable iff (srst_i)
        step_cnt < STEP_SLOW)
        else $error("step counter beyond slow interval");

endmodule

// File: sim/bldgc_pin_model.sv
// model of the logic and pwm source wired to the three pins
`timescale 1ns/1ps
module bldgc_pin_model (
    input wire logic clk_sys_i,
    input wire logic [2:0] gpio_out_i,
    input wire logic [2:0] gpio_oe_i,
    input wire logic [2:0] ext_drv_i,
    input wire logic [2:0] ext_lvl_i,
    output logic [2:0] pin_o
);
    // ------------------------------------------------------------
    // wire level
    // ------------------------------------------------------------
    logic [2:0] last;
    logic [2:0] lvl;
    initial last = 3'h0;
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (gpio_oe_i[i]) begin
                lvl[i] = gpio_out_i[i];
            end else if (ext_drv_i[i]) begin
                lvl[i] = ext_lvl_i[i];
            end else begin
                // floating pin, no pull: keep it moving, not settled
                lvl[i] = ~last[i];
            end
        end
    end
    always @(posedge clk_sys_i) begin
        last <= lvl;
    end
    assign pin_o = lvl;
endmodule

// File: sim/backlight_dimming_gpio_control_tb.sv
// self-checking bench for the backlight and pin controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
    begin compares++; if ((got) !== (ex)) begin \
    $display("Error %s expected %h seen %h", nm, ex, got); \
    fail_count++; end end
module backlight_dimming_gpio_control_tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce_i = 1'b1;
    bldgc_pkg::bldgc_reg_req_t req = '0;
    bldgc_pkg::bldgc_sink_t main_s;
    bldgc_pkg::bldgc_sink_t sub_s;
    logic [7:0] rdata;
    logic [2:0] pin, g_out, g_oe;
    logic [2:0] ext_drv = 3'h7;
    logic [2:0] ext_lvl = 3'h0;
    int fail_count = 0;
    int compares = 0;

    bldgc_top #(.STEP_SLOW(20'h0_0008), .STEP_FAST(20'h0_0004)) dut (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce_i),
        .reg_req_i(req), .main_sink_o(main_s), .sub_sink_o(sub_s),
        .reg_rdata_o(rdata), .gpio_in_i(pin), .gpio_out_o(g_out),
        .gpio_oe_o(g_oe));
    bldgc_pin_model pins (
        .clk_sys_i(clk_sys_i), .gpio_out_i(g_out), .gpio_oe_i(g_oe),
        .ext_drv_i(ext_drv), .ext_lvl_i(ext_lvl), .pin_o(pin));

    initial begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    // register select and one data byte, driven together for one strobe cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        #1 req = '{wr: 1'b1, addr: a, wdata: d};
        @(posedge clk_sys_i);
        #1 req.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] ex);
        @(posedge clk_sys_i);
        #1 req.addr = a;
        @(posedge clk_sys_i);
        #1 `CHK("rdata", ex, rdata)
    endtask
    function automatic bldgc_pkg::bldgc_sink_t sk(input logic on,
                                                  input logic [7:0] c);
        return bldgc_pkg::bldgc_sink_t'({on, c});
    endfunction
    // code, rate, select, enable, then target
    task automatic fade(input logic [7:0] ctl, input logic [7:0] a,
                        input logic [7:0] st, input logic [7:0] tg,
                        input int step, input logic use_sub);
        int n;
        int ex;
        logic [7:0] c;
        wr(8'h03, ctl & 8'hC7);
        wr(a, st);
        idle(4);
        wr(8'h03, ctl & 8'hE7);
        wr(8'h03, ctl & 8'hF7);
        wr(8'h03, ctl);
        wr(a, tg);
        n = 0;
        c = use_sub ? sub_s.code : main_s.code;
        while (c !== tg && n < 2000) begin
            idle(1);
            n++;
            c = use_sub ? sub_s.code : main_s.code;
        end
        ex = ((tg > st) ? (tg - st) : (st - tg)) * step;
        `CHK("fade_time", 1'b1, (n >= ex - 1 && n <= ex + 4))
    endtask

    // ------------------------------------------------------------
    // closing
    // ------------------------------------------------------------
    task automatic summarize();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        // watchdog: all tests take under 3000 cycles
        #(20000 * 5);
        fail_count++;
        summarize();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        logic [7:0] codes [3];
        codes = '{8'h00, 8'hFF, 8'h80};
        idle(5);
        srst_i = 1'b0;
        foreach (codes[i]) begin
            rd(8'h03 + 8'(i), 8'h00);
        end
        rd(8'h2B, 8'h00);
        rd(8'h10, bldgc_pkg::UNMAPPED_DATA);
        wr(8'h03, 8'h03);
        foreach (codes[i]) begin
            wr(8'h04, codes[i]);
            wr(8'h05, ~codes[i]);
            rd(8'h04, codes[i]);
            idle(3);
            `CHK("main", sk(1'b1, codes[i]), main_s)
            `CHK("sub", sk(1'b1, ~codes[i]), sub_s)
        end
        // clock enable low: the strobe must not be taken
        ce_i = 1'b0;
        wr(8'h04, 8'h55);
        ce_i = 1'b1;
        rd(8'h04, 8'h80);
        wr(8'h05, 8'h3C);
        wr(8'h03, 8'h07);
        idle(3);
        `CHK("shared", sk(1'b1, 8'h80), sub_s)
        wr(8'h03, 8'h02);
        idle(3);
        `CHK("sub_off", 1'b0, sub_s.on)
        `CHK("sub_own", 8'h3C, sub_s.code)
        wr(8'h03, 8'h01);
        idle(3);
        `CHK("main_off", 1'b0, main_s.on)
        // external gating through pin 0
        wr(8'h03, 8'h03);
        wr(8'h06, 8'h11);
        wr(8'h2B, 8'h03);
        rd(8'h2B, 8'h03);
        ext_lvl = 3'h1;
        idle(8);
        `CHK("pin0_in", 1'b0, g_oe[0])
        `CHK("gate_hi", 2'b11, {main_s.on, sub_s.on})
        ext_lvl = 3'h0;
        idle(8);
        `CHK("gate_lo", 2'b00, {main_s.on, sub_s.on})
        wr(8'h2B, 8'h02);
        idle(3);
        `CHK("sub_ungated", 2'b01, {main_s.on, sub_s.on})
        ext_lvl = 3'h6;
        idle(8);
        `CHK("pin12_no_pwm", 1'b0, main_s.on)
        // plain pin direction and data
        wr(8'h06, 8'h06);
        wr(8'h07, 8'h05);
        ext_lvl = 3'h1;
        idle(8);
        `CHK("oe", 3'h6, g_oe)
        `CHK("out", 3'h5, g_out)
        rd(8'h07, 8'h05);
        ext_lvl = 3'h0;
        wr(8'h07, 8'h03);
        idle(8);
        rd(8'h07, 8'h02);
        wr(8'h06, 8'h01);
        ext_lvl = 3'h6;
        idle(8);
        `CHK("oe0", 3'h1, g_oe)
        rd(8'h07, 8'h07);
        wr(8'h06, 8'h00);
        // fades: fast, slow, sub select, shared
        fade(8'h2A, 8'h04, 8'h10, 8'h14, 4, 1'b0);
        fade(8'h0A, 8'h04, 8'h14, 8'h10, 8, 1'b0);
        fade(8'h19, 8'h05, 8'h00, 8'h03, 8, 1'b1);
        wr(8'h04, 8'h40);
        idle(3);
        `CHK("main_direct", 8'h40, main_s.code)
        fade(8'h0F, 8'h04, 8'h40, 8'h44, 8, 1'b0);
        `CHK("shared_fade", 8'h44, sub_s.code)
        fade(8'h0F, 8'h04, 8'h44, 8'h46, 8, 1'b1);
        // mid-run reset clears codes and sinks
        srst_i = 1'b1;
        idle(2);
        srst_i = 1'b0;
        rd(8'h04, 8'h00);
        `CHK("main_rst", sk(1'b0, 8'h00), main_s)
        summarize();
    end
endmodule
